//--- src/ulf_line_format.sv
/*
  line format and line option logic of a single uart channel, with a
  small character transmitter and receiver that obey the format.
  assumes a classic wishbone master on mclk; ser_rx and ir_rx are
  asynchronous pins.
*/
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - divisor latch reachable only while line format bit 7 is set.
// - bit 6 set holds ser_tx low in modem mode until software clears it.
// - bits 5:3 pick none, odd, even, forced one or forced zero parity.
// - bit 2 gives one stop bit, or 1.5 (5-bit) / 2 stop bits.
// - bits 1:0 set 5 to 8 data bits for transmit and receive.
// - modem control bit 7 divides input clock by four before baud.
// - modem control bit 6 clear routes serial data to modem pins.
// - bit 6 set routes data via infrared coder; infrared output idles low.
module ulf_line_format (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ser_rx,
  input wire logic ir_rx,
  output logic ser_tx,
  output logic ir_tx
);
  // ==========================================================
  // parity helper
  function automatic logic par_of(input logic [7:0] d,
                                  input logic [1:0] wl,
                                  input logic [1:0] mode);
    logic [7:0] m;
    logic x;
    m = d & (8'hff >> (2'h3 - wl));
    x = ^m;
    case (mode)
      ulf_pkg::PAR_ODD: par_of = ~x;
      ulf_pkg::PAR_EVEN: par_of = x;
      ulf_pkg::PAR_ONE: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // bus and registers
  ulf_pkg::ulf_lfc_s lfc_ff, nxt_lfc;
  ulf_pkg::ulf_mlc_s mlc_ff, nxt_mlc;
  logic [15:0] div_ff, nxt_div;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic take, wr, rd_clr, tx_load;
  logic tx_busy, rx_valid_ff, rx_perr_ff, rx_ferr_ff;
  logic [7:0] rx_data_ff;

  always_comb begin
    take = wb_cyc_i & wb_stb_i & ack_ff;
    wr = take & wb_we_i;
    rd_clr = take & ~wb_we_i & (wb_adr_i == ulf_pkg::ADR_DATA);
    tx_load = wr & wb_sel_i[0] & (wb_adr_i == ulf_pkg::ADR_DATA)
              & ~tx_busy;
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_lfc = lfc_ff;
    nxt_mlc = mlc_ff;
    nxt_div = div_ff;
    if (wr & wb_sel_i[0] & (wb_adr_i == ulf_pkg::ADR_LFC)) begin
      nxt_lfc = wb_dat_i[7:0];
    end
    if (wr & wb_sel_i[0] & (wb_adr_i == ulf_pkg::ADR_MLC)) begin
      nxt_mlc = wb_dat_i[7:0];
    end
    if (wr & lfc_ff.dlab & (wb_adr_i == ulf_pkg::ADR_DIV)) begin
      if (wb_sel_i[0]) begin
        nxt_div[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        nxt_div[15:8] = wb_dat_i[15:8];
      end
    end
    nxt_dat = 32'h0;
    if (nxt_ack) begin
      case (wb_adr_i)
        ulf_pkg::ADR_LFC: nxt_dat[7:0] = lfc_ff;
        ulf_pkg::ADR_MLC: nxt_dat[7:0] = mlc_ff;
        ulf_pkg::ADR_DIV: begin
          if (lfc_ff.dlab) begin
            nxt_dat[15:0] = div_ff;
          end
        end
        ulf_pkg::ADR_DATA: nxt_dat[7:0] = rx_data_ff;
        ulf_pkg::ADR_STAT: begin
          nxt_dat[ulf_pkg::STAT_TX_BUSY] = tx_busy;
          nxt_dat[ulf_pkg::STAT_RX_VALID] = rx_valid_ff;
          nxt_dat[ulf_pkg::STAT_RX_PERR] = rx_perr_ff;
          nxt_dat[ulf_pkg::STAT_RX_FERR] = rx_ferr_ff;
        end
        default: nxt_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lfc_ff <= ulf_pkg::LFC_RST;
      mlc_ff <= ulf_pkg::MLC_RST;
      div_ff <= ulf_pkg::DIV_RST;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      lfc_ff <= nxt_lfc;
      mlc_ff <= nxt_mlc;
      div_ff <= nxt_div;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ==========================================================
  // baud tick, sixteen per bit
  logic [1:0] pre_ff, nxt_pre;
  logic [15:0] bcnt_ff, nxt_bcnt;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_pre = pre_ff + 2'h1;
    nxt_bcnt = bcnt_ff;
    nxt_tick = 1'b0;
    // divide by four only when selected, else every clock
    if (~mlc_ff.clk_div4 | (pre_ff == ulf_pkg::PRE_LAST)) begin
      if (bcnt_ff == 16'h0) begin
        nxt_tick = 1'b1;
        // a zero divisor behaves as one
        nxt_bcnt = (div_ff == 16'h0) ? 16'h0 : div_ff - 16'h1;
      end else begin
        nxt_bcnt = bcnt_ff - 16'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_ff <= 2'h0;
      bcnt_ff <= 16'h0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      bcnt_ff <= nxt_bcnt;
      tick_ff <= nxt_tick;
    end
  end

  // ==========================================================
  // transmitter
  ulf_pkg::ulf_state_e tx_st_ff, nxt_tx_st;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic [2:0] tx_bit_ff, nxt_tx_bit;
  logic [5:0] tx_tk_ff, nxt_tx_tk;
  logic tx_par_ff, nxt_tx_par;
  logic ser_tx_ff, nxt_ser_tx, ir_tx_ff, nxt_ir_tx;
  logic line, eff;
  logic [5:0] stop_len;
  logic [2:0] last_bit;

  always_comb begin
    last_bit = ulf_pkg::WLEN_BASE + {1'b0, lfc_ff.wlen};
    if (~lfc_ff.stop_long) begin
      stop_len = ulf_pkg::STOP_1;
    end else if (lfc_ff.wlen == ulf_pkg::WLEN_5) begin
      stop_len = ulf_pkg::STOP_15;
    end else begin
      stop_len = ulf_pkg::STOP_2;
    end
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_tk = tx_tk_ff;
    nxt_tx_par = tx_par_ff;
    if (tx_st_ff == ulf_pkg::ST_IDLE) begin
      if (tx_load) begin
        nxt_tx_st = ulf_pkg::ST_START;
        nxt_tx_sh = wb_dat_i[7:0];
        nxt_tx_par = par_of(wb_dat_i[7:0], lfc_ff.wlen, lfc_ff.par_mode);
        nxt_tx_bit = 3'h0;
        nxt_tx_tk = 6'h0;
      end
    end else if (tick_ff) begin
      nxt_tx_tk = tx_tk_ff + 6'h1;
      case (tx_st_ff)
        ulf_pkg::ST_START: begin
          if (tx_tk_ff == ulf_pkg::OVS_LAST) begin
            nxt_tx_st = ulf_pkg::ST_DATA;
            nxt_tx_tk = 6'h0;
          end
        end
        ulf_pkg::ST_DATA: begin
          if (tx_tk_ff == ulf_pkg::OVS_LAST) begin
            nxt_tx_tk = 6'h0;
            nxt_tx_sh = tx_sh_ff >> 1;
            nxt_tx_bit = tx_bit_ff + 3'h1;
            if (tx_bit_ff == last_bit) begin
              nxt_tx_st = lfc_ff.par_en ? ulf_pkg::ST_PAR
                                        : ulf_pkg::ST_STOP;
            end
          end
        end
        ulf_pkg::ST_PAR: begin
          if (tx_tk_ff == ulf_pkg::OVS_LAST) begin
            nxt_tx_st = ulf_pkg::ST_STOP;
            nxt_tx_tk = 6'h0;
          end
        end
        default: begin
          if (nxt_tx_tk >= stop_len) begin
            nxt_tx_st = ulf_pkg::ST_IDLE;
            nxt_tx_tk = 6'h0;
          end
        end
      endcase
    end
    case (tx_st_ff)
      ulf_pkg::ST_START: line = 1'b0;
      ulf_pkg::ST_DATA: line = tx_sh_ff[0];
      ulf_pkg::ST_PAR: line = tx_par_ff;
      default: line = 1'b1;
    endcase
    eff = line & ~lfc_ff.brk;
    // pin not in use rests at its idle level
    nxt_ser_tx = mlc_ff.ir_en | eff;
    nxt_ir_tx = mlc_ff.ir_en & ~eff
                & (tx_tk_ff < ulf_pkg::IR_PULSE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_st_ff <= ulf_pkg::ST_IDLE;
      tx_sh_ff <= 8'h0;
      tx_bit_ff <= 3'h0;
      tx_tk_ff <= 6'h0;
      tx_par_ff <= 1'b0;
      ser_tx_ff <= 1'b1;
      ir_tx_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_bit_ff <= nxt_tx_bit;
      tx_tk_ff <= nxt_tx_tk;
      tx_par_ff <= nxt_tx_par;
      ser_tx_ff <= nxt_ser_tx;
      ir_tx_ff <= nxt_ir_tx;
    end
  end

  assign tx_busy = (tx_st_ff != ulf_pkg::ST_IDLE);
  assign ser_tx = ser_tx_ff;
  assign ir_tx = ir_tx_ff;

  // ==========================================================
  // receiver
  ulf_pkg::ulf_state_e rx_st_ff, nxt_rx_st;
  logic [7:0] rx_sh_ff, nxt_rx_sh, nxt_rx_data;
  logic [2:0] rx_bit_ff, nxt_rx_bit;
  logic [5:0] rx_tk_ff, nxt_rx_tk, irs_ff, nxt_irs;
  logic rx_s1_ff, rx_s2_ff, ir_s1_ff, ir_s2_ff, ir_prev_ff;
  logic rpe_ff, nxt_rpe, nxt_valid, nxt_perr, nxt_ferr, rline, done;

  always_comb begin
    // a short infrared pulse marks a zero; stretch it over a bit
    nxt_irs = irs_ff;
    if (ir_s2_ff & ~ir_prev_ff) begin
      nxt_irs = ulf_pkg::IR_STRETCH;
    end else if (tick_ff & (irs_ff != 6'h0)) begin
      nxt_irs = irs_ff - 6'h1;
    end
    rline = mlc_ff.ir_en ? (irs_ff == 6'h0) : rx_s2_ff;
    nxt_rx_st = rx_st_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_tk = rx_tk_ff;
    nxt_rpe = rpe_ff;
    nxt_rx_data = rx_data_ff;
    done = 1'b0;
    if (rx_st_ff == ulf_pkg::ST_IDLE) begin
      if (~rline) begin
        nxt_rx_st = ulf_pkg::ST_START;
        nxt_rx_tk = 6'h0;
      end
    end else if (tick_ff) begin
      nxt_rx_tk = rx_tk_ff + 6'h1;
      case (rx_st_ff)
        ulf_pkg::ST_START: begin
          if (rx_tk_ff == ulf_pkg::OVS_HALF) begin
            // a start shorter than half a bit is a glitch
            nxt_rx_st = rline ? ulf_pkg::ST_IDLE : ulf_pkg::ST_DATA;
            nxt_rx_tk = 6'h0;
            nxt_rx_bit = 3'h0;
            nxt_rx_sh = 8'h0;
            nxt_rpe = 1'b0;
          end
        end
        ulf_pkg::ST_DATA: begin
          if (rx_tk_ff == ulf_pkg::OVS_LAST) begin
            nxt_rx_tk = 6'h0;
            nxt_rx_sh[rx_bit_ff] = rline;
            nxt_rx_bit = rx_bit_ff + 3'h1;
            if (rx_bit_ff == last_bit) begin
              nxt_rx_st = lfc_ff.par_en ? ulf_pkg::ST_PAR
                                        : ulf_pkg::ST_STOP;
            end
          end
        end
        ulf_pkg::ST_PAR: begin
          if (rx_tk_ff == ulf_pkg::OVS_LAST) begin
            nxt_rx_tk = 6'h0;
            nxt_rpe = rline
                      ^ par_of(rx_sh_ff, lfc_ff.wlen, lfc_ff.par_mode);
            nxt_rx_st = ulf_pkg::ST_STOP;
          end
        end
        default: begin
          // only the first stop bit is checked
          if (rx_tk_ff == ulf_pkg::OVS_LAST) begin
            done = 1'b1;
            nxt_rx_data = rx_sh_ff;
            nxt_rx_st = ulf_pkg::ST_IDLE;
          end
        end
      endcase
    end
    // a new character beats a read clearing the flags
    nxt_valid = done | (rx_valid_ff & ~rd_clr);
    nxt_perr = done ? rpe_ff : (rx_perr_ff & ~rd_clr);
    nxt_ferr = done ? ~rline : (rx_ferr_ff & ~rd_clr);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      ir_s1_ff <= 1'b0;
      ir_s2_ff <= 1'b0;
      ir_prev_ff <= 1'b0;
      irs_ff <= 6'h0;
      rx_st_ff <= ulf_pkg::ST_IDLE;
      rx_sh_ff <= 8'h0;
      rx_bit_ff <= 3'h0;
      rx_tk_ff <= 6'h0;
      rpe_ff <= 1'b0;
      rx_data_ff <= 8'h0;
      rx_valid_ff <= 1'b0;
      rx_perr_ff <= 1'b0;
      rx_ferr_ff <= 1'b0;
    end else begin
      rx_s1_ff <= ser_rx;
      rx_s2_ff <= rx_s1_ff;
      ir_s1_ff <= ir_rx;
      ir_s2_ff <= ir_s1_ff;
      ir_prev_ff <= ir_s2_ff;
      irs_ff <= nxt_irs;
      rx_st_ff <= nxt_rx_st;
      rx_sh_ff <= nxt_rx_sh;
      rx_bit_ff <= nxt_rx_bit;
      rx_tk_ff <= nxt_rx_tk;
      rpe_ff <= nxt_rpe;
      rx_data_ff <= nxt_rx_data;
      rx_valid_ff <= nxt_valid;
      rx_perr_ff <= nxt_perr;
      rx_ferr_ff <= nxt_ferr;
    end
  end
endmodule

//--- common/ulf_pkg.sv
/*
  shared constants, types and register map of the line format block.
  assumes a 32-bit classic wishbone slave port with byte addresses.
*/
package ulf_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADR_LFC = 8'h00;
  localparam logic [7:0] ADR_MLC = 8'h04;
  localparam logic [7:0] ADR_DIV = 8'h08;
  localparam logic [7:0] ADR_DATA = 8'h0c;
  localparam logic [7:0] ADR_STAT = 8'h10;
  // ==========================================================
  // reset values
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [7:0] MLC_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // ==========================================================
  // status bit positions
  localparam int STAT_TX_BUSY = 0;
  localparam int STAT_RX_VALID = 1;
  localparam int STAT_RX_PERR = 2;
  localparam int STAT_RX_FERR = 3;
  // ==========================================================
  // field encodings
  localparam logic [1:0] PAR_ODD = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ONE = 2'h2;
  localparam logic [1:0] PAR_ZERO = 2'h3;
  localparam logic [1:0] WLEN_5 = 2'h0;
  localparam logic [2:0] WLEN_BASE = 3'h4;
  // ==========================================================
  // timing in oversample ticks (16 per bit)
  localparam logic [5:0] OVS_LAST = 6'h0f;
  localparam logic [5:0] OVS_HALF = 6'h07;
  localparam logic [5:0] STOP_1 = 6'h10;
  localparam logic [5:0] STOP_15 = 6'h18;
  localparam logic [5:0] STOP_2 = 6'h20;
  localparam logic [5:0] IR_PULSE = 6'h03;
  localparam logic [5:0] IR_STRETCH = 6'h10;
  localparam logic [1:0] PRE_LAST = 2'h3;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } ulf_state_e;

  typedef struct packed {
    logic dlab;
    logic brk;
    logic [1:0] par_mode;
    logic par_en;
    logic stop_long;
    logic [1:0] wlen;
  } ulf_lfc_s;

  typedef struct packed {
    logic clk_div4;
    logic ir_en;
    logic [5:0] other;
  } ulf_mlc_s;
endpackage

//--- sim/ulf_line_format_assertions.sv
/*
  port checks of the line format block, bound at the foot.
  assumes divisor stays 1 and modes change only while the line idles.
*/
`timescale 1ns/1ps
module ulf_lf_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ser_tx,
  input wire logic ir_tx
);
  // ==========================================================
  // shadow of written control bits
  logic b7_ff, brk_ff, ir_ff;
  wire wr_hit = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      b7_ff <= 1'b0;
      brk_ff <= 1'b0;
      ir_ff <= 1'b0;
    end else if (wr_hit && wb_adr_i == ulf_pkg::ADR_LFC) begin
      b7_ff <= wb_dat_i[7];
      brk_ff <= wb_dat_i[6];
    end else if (wr_hit && wb_adr_i == ulf_pkg::ADR_MLC) begin
      ir_ff <= wb_dat_i[6];
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_div_hidden; wb_ack_o && !wb_we_i && !b7_ff &&
    wb_adr_i == ulf_pkg::ADR_DIV |-> wb_dat_o == 32'h0; endproperty
  a_div_hidden: assert property (p_div_hidden) else $error("div seen");
  property p_break_low; brk_ff && $past(brk_ff) && !ir_ff |-> !ser_tx;
  endproperty
  a_break_low: assert property (p_break_low) else $error("no break");
  property p_ir_quiet; ir_ff && $past(ir_ff) && !brk_ff |-> ser_tx;
  endproperty
  a_ir_quiet: assert property (p_ir_quiet) else $error("serial on");
  property p_modem_ir; !ir_ff && !$past(ir_ff) |-> !ir_tx; endproperty
  a_modem_ir: assert property (p_modem_ir) else $error("ir active");
  property p_ir_pulse; $rose(ir_tx) |-> ir_tx [*3]; endproperty
  a_ir_pulse: assert property (p_ir_pulse) else $error("ir short");
  property p_start_len; $fell(ser_tx) && !brk_ff && !$past(brk_ff) |->
    !ser_tx [*8]; endproperty
  a_start_len: assert property (p_start_len) else $error("bit short");
endmodule
bind ulf_line_format ulf_lf_chk i_ulf_lf_chk (
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ser_tx(ser_tx), .ir_tx(ir_tx)
);

//--- sim/ulf_peer.sv
/*
  remote serial peer: samples frames off the line, sends frames back.
  assumes bt is set to the bit time in mclk cycles before each use.
*/
`timescale 1ns/1ps
module ulf_peer (
  input wire logic mclk,
  input wire logic ser_tx,
  output logic ser_rx,
  output logic ir_rx
);
  int bt = 16;
  initial begin
    ser_rx = 1'b1;
    ir_rx = 1'b0;
  end
  // mid-bit sampling, start bit lands in v[0]
  task automatic take(input int nb, output logic [11:0] v);
    int i;
    v = 12'h0;
    for (i = 0; i < 4000 && ser_tx === 1'b1; i++) @(posedge mclk);
    repeat (bt / 2) @(posedge mclk);
    for (i = 0; i < nb; i++) begin
      v[i] = ser_tx;
      repeat (bt) @(posedge mclk);
    end
  endtask
  // v holds start, data lsb first, parity, stop; line idles high
  task automatic send(input logic [11:0] v, input int nb);
    int i;
    for (i = 0; i < nb; i++) begin
      @(posedge mclk);
      ser_rx <= v[i];
      repeat (bt - 1) @(posedge mclk);
    end
    @(posedge mclk);
    ser_rx <= 1'b1;
  endtask
  // infrared: a 3-cycle high pulse marks each zero bit, ones stay low
  task automatic send_ir(input logic [11:0] v, input int nb);
    int i;
    for (i = 0; i < nb; i++) begin
      @(posedge mclk);
      ir_rx <= ~v[i];
      repeat (3) @(posedge mclk);
      ir_rx <= 1'b0;
      repeat (bt - 4) @(posedge mclk);
    end
  endtask
endmodule

//--- sim/test_ulf_line_format.sv
/*
  bench of the line format block: registers, break, frames, receive, ir.
  assumes the peer model on the serial pins and divisor left at 1.
*/
`timescale 1ns/1ps
module test_ulf_line_format;
  // ==========================================================
  // signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, ser_rx, ir_rx, ser_tx, ir_tx;
  logic [11:0] fv;
  int mismatches = 0;
  int n_tests = 0;
  int cnum = 0;
  int ir_hi = 0;
  int t0, e, k, u, n, d;
  logic [7:0] cfg [6] = '{8'h00, 8'h0d, 8'h1e, 8'h2b, 8'h3c, 8'h34};
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cnum <= cnum + 1;
    ir_hi <= ir_hi + int'(ir_tx === 1'b1);
  end
  ulf_line_format i_ulf_line_format (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ser_rx(ser_rx), .ir_rx(ir_rx), .ser_tx(ser_tx),
    .ir_tx(ir_tx)
  );
  ulf_peer i_ulf_peer (
    .mclk(mclk), .ser_tx(ser_tx), .ser_rx(ser_rx), .ir_rx(ir_rx)
  );
  // ==========================================================
  // tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge mclk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h3, v};
    for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge mclk);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (i == 50) begin
      mismatches++;
      close_out();
    end
  endtask
  // poll busy; a bounded count keeps a stuck transmitter from hanging
  task automatic idle();
    int i;
    for (i = 0; i < 3000; i++) begin
      bus(1'b0, ulf_pkg::ADR_STAT, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (i == 3000) begin
      mismatches++;
      close_out();
    end
  endtask
  function automatic logic [11:0] frame(input logic [7:0] c, dv);
    logic [11:0] v;
    logic [7:0] m;
    logic p;
    m = dv & (8'hff >> (3 - c[1:0]));
    p = (c[5:4] == 2'h0) ? ~^m : (c[5:4] == 2'h1) ? ^m : ~c[4];
    v = {3'h0, m, 1'b0};
    v[6 + c[1:0] +: 2] = c[3] ? {1'b1, p} : 2'b01;
    return v;
  endfunction
  task automatic tx(input logic [7:0] c, input logic [7:0] mc);
    bus(1'b1, ulf_pkg::ADR_LFC, {24'h0, c});
    bus(1'b1, ulf_pkg::ADR_MLC, {24'h0, mc});
    u = mc[7] ? 4 : 1;
    n = 5 + c[1:0];
    i_ulf_peer.bt = 16 * u;
    e = u * (16 * (1 + n + c[3]) + (!c[2] ? 16 : (n == 5 ? 24 : 32)));
    bus(1'b1, ulf_pkg::ADR_DATA, 32'h1b3);
    t0 = cnum;
    // time to busy low; the peer's sampling runs on past the stop bit
    fork
      i_ulf_peer.take(n + 2 + c[3], fv);
      begin
        idle();
        d = cnum - t0;
      end
    join
    chk("frame", {20'h0, fv}, {20'h0, frame(c, 8'hb3)});
    chk("frame time", {31'h0, d >= e - 2 && d <= e + 4 * u + 2}, 1);
  endtask
  task automatic rx(input logic [11:0] v, input logic [31:0] st,
                    input logic ir);
    if (ir) i_ulf_peer.send_ir(v, 11);
    else i_ulf_peer.send(v, 11);
    idle();
    bus(1'b0, ulf_pkg::ADR_STAT, 32'h0);
    chk("rx status", q & 32'he, st);
    bus(1'b0, ulf_pkg::ADR_DATA, 32'h0);
    chk("rx data", q, 32'ha5);
  endtask
  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, ulf_pkg::ADR_LFC, 32'h0);
    chk("lfc reset", q, 32'h0);
    bus(1'b0, ulf_pkg::ADR_MLC, 32'h0);
    chk("mlc reset", q, 32'h0);
    bus(1'b0, ulf_pkg::ADR_DIV, 32'h0);
    chk("div hidden", q, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, ulf_pkg::ADR_DIV, 32'h1234);
    bus(1'b1, ulf_pkg::ADR_LFC, 32'hff);
    bus(1'b0, ulf_pkg::ADR_LFC, 32'h0);
    chk("lfc rw", q, 32'hff);
    bus(1'b0, ulf_pkg::ADR_DIV, 32'h0);
    chk("div open", q, 32'h1);
    bus(1'b1, ulf_pkg::ADR_DIV, 32'h2);
    bus(1'b0, ulf_pkg::ADR_DIV, 32'h0);
    chk("div rw", q, 32'h2);
    bus(1'b1, ulf_pkg::ADR_DIV, 32'h1);
    repeat (40) @(posedge mclk);
    chk("break", ser_tx, 1'b0);
    bus(1'b1, ulf_pkg::ADR_LFC, 32'h0);
    repeat (4) @(posedge mclk);
    chk("no break", ser_tx, 1'b1);
    $display("registers and break done");
    for (int c = 0; c < 6; c++) tx(cfg[c], c == 0 ? 8'h00 : 8'h80);
    $display("frames done");
    bus(1'b1, ulf_pkg::ADR_LFC, 32'h1b);
    bus(1'b1, ulf_pkg::ADR_MLC, 32'h0);
    i_ulf_peer.bt = 16;
    rx(12'h54a, 32'h2, 1'b0);
    rx(12'h74a, 32'h6, 1'b0);
    $display("receive done");
    bus(1'b1, ulf_pkg::ADR_MLC, 32'h40);
    bus(1'b1, ulf_pkg::ADR_LFC, 32'h0);
    k = ir_hi;
    bus(1'b1, ulf_pkg::ADR_DATA, 32'h0);
    idle();
    chk("ir pulses", ir_hi - k, 32'd18);
    chk("ir serial", ser_tx, 1'b1);
    bus(1'b1, ulf_pkg::ADR_LFC, 32'h1b);
    rx(12'h54a, 32'h2, 1'b1);
    $display("infrared done");
    close_out();
  end
endmodule
